// *** design/lpc_pkg.sv ***
// Constants, register map and carrier types of the low-power mode controller.
// Assumes one always-running system clock at 200 MHz and an APB master with 32-bit data.

package lpc_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned WAKE_SRAM_NS   = 5000;
  localparam int unsigned WAKE_FLASH_NS  = 70000;
  localparam int unsigned WAKE_SRAM_CYC  = (WAKE_SRAM_NS * CLK_MHZ) / 1000;
  localparam int unsigned WAKE_FLASH_CYC = (WAKE_FLASH_NS * CLK_MHZ) / 1000;
  localparam int unsigned WAKE_LAT       = 5;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned WAKE_PINS      = 16;
  localparam int unsigned DIV_W          = 4;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_MAIN_OSC  = 8'h00;
  localparam logic [7:0] ADDR_FSMR      = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_PCER      = 8'h0c;
  localparam logic [7:0] ADDR_DIV       = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int unsigned MOR_WAIT_BIT    = 0;
  localparam int unsigned MOR_SRC_LSB     = 1;
  localparam int unsigned FSMR_RTT_BIT    = 16;
  localparam int unsigned FSMR_RTC_BIT    = 17;
  localparam int unsigned FSMR_LP_BIT     = 20;
  localparam int unsigned FSMR_FLASH_LSB  = 21;
  localparam int unsigned STAT_MCR_BIT    = 0;
  localparam int unsigned STAT_STATE_LSB  = 1;
  localparam int unsigned STAT_EVT_BIT    = 4;
  localparam int unsigned STAT_RC_BIT     = 5;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    SRC_FAST_RC = 2'h0,
    SRC_XTAL    = 2'h1,
    SRC_PLL     = 2'h2
  } lpc_clk_src_t;

  typedef enum logic [1:0] {
    FLASH_STANDBY = 2'h0,
    FLASH_DEEP_PD = 2'h1,
    FLASH_IDLE    = 2'h2,
    FLASH_ON      = 2'h3
  } lpc_flash_mode_t;

  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'h0,
    ST_ENTER   = 3'h1,
    ST_WAIT    = 3'h3,
    ST_RESTART = 3'h2,
    ST_SLEEP   = 3'h4
  } lpc_state_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                 rtc_en;
    logic                 rtt_en;
    logic [WAKE_PINS-1:0] pin_en;
  } lpc_wake_cfg_t;

  typedef struct packed {
    logic wake_late;
    logic sleep_exit;
    logic wfe_refused;
    logic wake_done;
  } lpc_irq_t;

  localparam int unsigned IRQ_W = $bits(lpc_irq_t);

  // Reset values
  localparam lpc_clk_src_t     SRC_RST   = SRC_FAST_RC;
  localparam logic [DIV_W-1:0] DIV_RST   = 4'h0;
  localparam logic [1:0]       FLASH_RST = 2'h0;

endpackage : lpc_pkg

// *** design/lpc_wake_detect.sv ***
// Clockless wake-source detector of the low-power mode controller.
// Assumes wake sources are active low and that arm_i is a settled level from the controller.
`timescale 1ns/100ps

module lpc_wake_detect
  import lpc_pkg::*;
(
  // Configuration
  input  wire lpc_wake_cfg_t        cfg_i,
  input  wire logic                 arm_i,
  // Wake sources, active low
  input  wire logic [WAKE_PINS-1:0] wake_pins_n_i,
  input  wire logic                 rtt_alarm_n_i,
  input  wire logic                 rtc_alarm_n_i,
  // Fast start-up request, active high, not clocked
  output logic                      fast_startup_o
);

  logic [WAKE_PINS-1:0] pin_hit;
  logic                 any_pin;
  logic                 alarm_hit;

  // ==========================================================================
  // Per-pin qualification
  genvar g;
  generate
    for (g = 0; g < WAKE_PINS; g++) begin : g_pin
      assign pin_hit[g] = cfg_i.pin_en[g] & ~wake_pins_n_i[g];
    end
  endgenerate

  assign any_pin   = |pin_hit;
  assign alarm_hit = (cfg_i.rtt_en & ~rtt_alarm_n_i) | (cfg_i.rtc_en & ~rtc_alarm_n_i);

  // Pure gates, so a low level is seen with every clock stopped.
  assign fast_startup_o = arm_i & (any_pin | alarm_hit);

endmodule // lpc_wake_detect

// *** design/lpc_ctrl.sv ***
// Low-power mode controller: active, sleep and wait modes with fast start-up.
// Assumes CLK_SYS_I stays running in every mode and the APB master is on CLK_SYS_I.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module lpc_ctrl
  import lpc_pkg::*;
#(
  parameter int unsigned PERIPH_N       = 8,
  parameter int unsigned WAKE_FLASH_LIM = WAKE_FLASH_CYC
) (
  // Clock and reset
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 RSTN_I,
  // APB slave
  input  wire logic                 PSEL_I,
  input  wire logic                 PENABLE_I,
  input  wire logic                 PWRITE_I,
  input  wire logic [7:0]           PADDR_I,
  input  wire logic [31:0]          PWDATA_I,
  output logic      [31:0]          PRDATA_O,
  output logic                      PREADY_O,
  output logic                      PSLVERR_O,
  // Processor core
  input  wire logic                 WFE_I,
  input  wire logic                 WFI_I,
  input  wire logic                 DEEP_SLEEP_I,
  input  wire logic                 IRQ_I,
  input  wire logic                 DBG_EVENT_I,
  input  wire logic                 RX_EVENT_I,
  input  wire logic                 CODE_IN_FLASH_I,
  // Wake sources, active low
  input  wire logic [WAKE_PINS-1:0] WAKE_PINS_N_I,
  input  wire logic                 RTT_ALARM_N_I,
  input  wire logic                 RTC_ALARM_N_I,
  // Fast RC oscillator
  input  wire logic                 RC_READY_I,
  // Clock and power control
  output logic                      CORE_CLK_EN_O,
  output logic                      MEM_CLK_EN_O,
  output logic [PERIPH_N-1:0]       PERIPH_CLK_EN_O,
  output logic [1:0]                CLK_SRC_SEL_O,
  output logic [DIV_W-1:0]          CLK_DIV_O,
  output logic                      RC_RESTART_O,
  output logic [1:0]                FLASH_MODE_O,
  output logic                      SUPPLY_HOLD_O,
  output logic                      IO_HOLD_O,
  output logic                      FAST_STARTUP_O,
  output logic                      MASTER_CLOCK_READY_O,
  output logic                      IRQ_O
);

  // ==========================================================================
  // Declarations
  lpc_state_t          state_q, state_d;
  lpc_clk_src_t        clk_src_q;
  lpc_wake_cfg_t       wake_cfg_q;
  lpc_irq_t            irq_set;
  logic [IRQ_W-1:0]    irq_stat_q, irq_stat_d, irq_mask_q;
  logic [PERIPH_N-1:0] pcer_q;
  logic [DIV_W-1:0]    div_q;
  logic                lp_bit_q;
  logic [1:0]          flash_sel_q;
  logic                wait_req_q;
  logic                evt_q;
  logic                irq_dly_q;
  logic                from_flash_q;
  logic [CNT_W-1:0]    budget_q, cnt_q;
  logic                wait_arm_q;
  logic                wake_async;
  logic [1:0]          sync1_q, sync2_q, sync3_q, stable_q;
  logic                wake_s, rc_ready_s;
  logic                new_evt, evt_now, wfe_seen, wfe_ok, wfe_refuse;
  logic                wait_go, sleep_go, deadline;
  logic                apb_setup, apb_wr, addr_ok;
  logic [31:0]         rd_data;
  logic [31:0]         status_word;

  // ==========================================================================
  // Asynchronous wake detector
  lpc_wake_detect u_wake_detect (
    .cfg_i          (wake_cfg_q),
    .arm_i          (wait_arm_q),
    .wake_pins_n_i  (WAKE_PINS_N_I),
    .rtt_alarm_n_i  (RTT_ALARM_N_I),
    .rtc_alarm_n_i  (RTC_ALARM_N_I),
    .fast_startup_o (wake_async)
  );

  // Arms the detector only while the clocks are stopped in wait mode.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wait_arm_q <= 1'b0;
    end else begin
      wait_arm_q <= (state_d == ST_WAIT);
    end
  end

  // ==========================================================================
  // Input synchronisers: a change counts once the second and third stages agree
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_q  <= 2'h0;
      sync2_q  <= 2'h0;
      sync3_q  <= 2'h0;
      stable_q <= 2'h0;
    end else begin
      sync1_q <= {RC_READY_I, wake_async};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  assign wake_s     = stable_q[0];
  assign rc_ready_s = stable_q[1];

  // ==========================================================================
  // Core event flag
  assign new_evt  = (IRQ_I & ~irq_dly_q) | DBG_EVENT_I | RX_EVENT_I;
  assign evt_now  = evt_q | new_evt;
  assign wfe_seen = (state_q == ST_ACTIVE) & WFE_I & lp_bit_q & ~DEEP_SLEEP_I;
  assign wfe_ok     = wfe_seen & ~evt_now;
  assign wfe_refuse = wfe_seen & evt_now;

  // An event in the same cycle as the instruction is counted before it is consumed.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      evt_q     <= 1'b0;
      irq_dly_q <= 1'b0;
    end else begin
      irq_dly_q <= IRQ_I;
      if (wfe_seen) begin
        evt_q <= 1'b0;
      end else if (new_evt) begin
        evt_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Mode sequencer
  assign wait_go  = wait_req_q | wfe_ok;
  assign sleep_go = (state_q == ST_ACTIVE) & WFI_I & ~DEEP_SLEEP_I & ~lp_bit_q;
  assign deadline = (cnt_q >= budget_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (wait_go) begin
          state_d = ST_ENTER;
        end else if (sleep_go) begin
          state_d = ST_SLEEP;
        end
      end
      ST_ENTER: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (wake_s) begin
          state_d = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (rc_ready_s || deadline) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_SLEEP: begin
        if (IRQ_I) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Wake deadline: budget chosen by where the entry code ran
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      from_flash_q <= 1'b0;
      budget_q     <= '0;
      cnt_q        <= '0;
    end else begin
      if (state_q == ST_ACTIVE && wait_go) begin
        from_flash_q <= CODE_IN_FLASH_I;
        if (CODE_IN_FLASH_I) begin
          budget_q <= CNT_W'(WAKE_FLASH_LIM - WAKE_LAT);
        end else begin
          budget_q <= CNT_W'(WAKE_SRAM_CYC - WAKE_LAT);
        end
      end
      if (state_q == ST_RESTART) begin
        cnt_q <= cnt_q + 1'b1;
      end else begin
        cnt_q <= '0;
      end
    end
  end

  // ==========================================================================
  // Clock, flash and I/O controls, registered from the next state, supply hold held high; fast start-up from the current state and wake_s
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CORE_CLK_EN_O        <= 1'b1;
      MEM_CLK_EN_O         <= 1'b1;
      PERIPH_CLK_EN_O      <= '0;
      RC_RESTART_O         <= 1'b0;
      FLASH_MODE_O         <= FLASH_ON;
      SUPPLY_HOLD_O        <= 1'b1;
      IO_HOLD_O            <= 1'b0;
      FAST_STARTUP_O       <= 1'b0;
      MASTER_CLOCK_READY_O <= 1'b1;
    end else begin
      CORE_CLK_EN_O <= (state_d == ST_ACTIVE);
      MEM_CLK_EN_O  <= (state_d == ST_ACTIVE) || (state_d == ST_SLEEP);
      if ((state_d == ST_ACTIVE) || (state_d == ST_SLEEP)) begin
        PERIPH_CLK_EN_O <= pcer_q;
      end else begin
        PERIPH_CLK_EN_O <= '0;
      end
      RC_RESTART_O <= (state_d == ST_RESTART);
      if ((state_d == ST_ENTER) || (state_d == ST_WAIT)) begin
        if (flash_sel_q == FLASH_ON) begin
          FLASH_MODE_O <= FLASH_STANDBY;
        end else begin
          FLASH_MODE_O <= flash_sel_q;
        end
      end else begin
        FLASH_MODE_O <= FLASH_ON;
      end
      SUPPLY_HOLD_O        <= 1'b1;
      IO_HOLD_O            <= (state_d != ST_ACTIVE);
      FAST_STARTUP_O       <= (state_q == ST_WAIT) & wake_s;
      MASTER_CLOCK_READY_O <= (state_d == ST_ACTIVE) || (state_d == ST_SLEEP);
    end
  end

  // ==========================================================================
  // APB slave: one wait-free access phase, read data captured at setup
  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & ~PSLVERR_O;

  assign status_word = {26'h0, rc_ready_s, evt_q, state_q, MASTER_CLOCK_READY_O};

  always_comb begin
    rd_data = 32'h0;
    addr_ok = 1'b1;
    unique case (PADDR_I)
      ADDR_MAIN_OSC: begin
        rd_data[MOR_SRC_LSB +: 2] = clk_src_q;
      end
      ADDR_FSMR: begin
        rd_data[WAKE_PINS-1:0]        = wake_cfg_q.pin_en;
        rd_data[FSMR_RTT_BIT]         = wake_cfg_q.rtt_en;
        rd_data[FSMR_RTC_BIT]         = wake_cfg_q.rtc_en;
        rd_data[FSMR_LP_BIT]          = lp_bit_q;
        rd_data[FSMR_FLASH_LSB +: 2]  = flash_sel_q;
      end
      ADDR_STATUS: begin
        rd_data = status_word;
      end
      ADDR_PCER: begin
        rd_data[PERIPH_N-1:0] = pcer_q;
      end
      ADDR_DIV: begin
        rd_data[DIV_W-1:0] = div_q;
      end
      ADDR_IRQ_STAT: begin
        rd_data[IRQ_W-1:0] = irq_stat_q;
      end
      ADDR_IRQ_MASK: begin
        rd_data[IRQ_W-1:0] = irq_mask_q;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
    end else begin
      PREADY_O <= apb_setup;
      if (apb_setup) begin
        PSLVERR_O <= ~addr_ok;
        PRDATA_O  <= PWRITE_I ? 32'h0 : rd_data;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clk_src_q   <= SRC_RST;
      wake_cfg_q  <= '0;
      lp_bit_q    <= 1'b0;
      flash_sel_q <= FLASH_RST;
      pcer_q      <= '0;
      div_q       <= DIV_RST;
    end else begin
      if ((state_q == ST_WAIT) && wake_s) begin
        clk_src_q <= SRC_FAST_RC;
      end else if (apb_wr && (PADDR_I == ADDR_MAIN_OSC)) begin
        if (PWDATA_I[MOR_SRC_LSB +: 2] != 2'h3) begin
          clk_src_q <= lpc_clk_src_t'(PWDATA_I[MOR_SRC_LSB +: 2]);
        end
      end
      if (apb_wr && (PADDR_I == ADDR_FSMR)) begin
        wake_cfg_q.pin_en <= PWDATA_I[WAKE_PINS-1:0];
        wake_cfg_q.rtt_en <= PWDATA_I[FSMR_RTT_BIT];
        wake_cfg_q.rtc_en <= PWDATA_I[FSMR_RTC_BIT];
        lp_bit_q          <= PWDATA_I[FSMR_LP_BIT];
        flash_sel_q       <= PWDATA_I[FSMR_FLASH_LSB +: 2];
      end
      if (apb_wr && (PADDR_I == ADDR_PCER)) begin
        pcer_q <= PWDATA_I[PERIPH_N-1:0];
      end
      if (apb_wr && (PADDR_I == ADDR_DIV)) begin
        div_q <= PWDATA_I[DIV_W-1:0];
      end
    end
  end

  assign CLK_SRC_SEL_O = clk_src_q;
  assign CLK_DIV_O     = div_q;

  // Wait request bit: self-clearing, taken once the sequencer leaves active.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wait_req_q <= 1'b0;
    end else begin
      if (apb_wr && (PADDR_I == ADDR_MAIN_OSC) && PWDATA_I[MOR_WAIT_BIT]) begin
        wait_req_q <= 1'b1;
      end else if (state_q == ST_ENTER) begin
        wait_req_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  always_comb begin
    irq_set             = '0;
    irq_set.wake_done   = (state_q == ST_RESTART) && (state_d == ST_ACTIVE);
    irq_set.wfe_refused = wfe_refuse;
    irq_set.sleep_exit  = (state_q == ST_SLEEP) && (state_d == ST_ACTIVE);
    irq_set.wake_late   = (state_q == ST_RESTART) && deadline && !rc_ready_s;
    irq_stat_d          = irq_stat_q;
    if (apb_wr && (PADDR_I == ADDR_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~PWDATA_I[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_set;
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      IRQ_O      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (apb_wr && (PADDR_I == ADDR_IRQ_MASK)) begin
        irq_mask_q <= PWDATA_I[IRQ_W-1:0];
      end
      IRQ_O <= |(irq_stat_d & irq_mask_q);
    end
  end

endmodule // lpc_ctrl

// *** dv/lpc_rc_model.sv ***
// Fast RC oscillator model that sits at the far side of the power manager.
// Assumes restart_i and mck_ready_i come straight from the controller outputs.
`timescale 1ns/100ps

module lpc_rc_model #(
  parameter int unsigned START_CYC = 30
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Controller side
  input  wire logic restart_i,
  input  wire logic mck_ready_i,
  output logic      rc_ready_o
);
  int unsigned cnt_q;

  // The oscillator counts its start-up only while a restart is requested.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 0;
    end else if (!restart_i) begin
      cnt_q <= 0;
    end else if (cnt_q < START_CYC) begin
      cnt_q <= cnt_q + 1;
    end
  end

  assign rc_ready_o = mck_ready_i || (cnt_q == START_CYC);
endmodule // lpc_rc_model

// *** dv/lpc_ctrl_checker.sv ***
// Port-level assertions for the low-power mode controller.
// Assumes it is bound into lpc_ctrl and sees only its ports.
`timescale 1ns/100ps

module lpc_ctrl_checker
  import lpc_pkg::*;
#(
  parameter int unsigned PERIPH_N       = 8,
  parameter int unsigned WAKE_FLASH_LIM = WAKE_FLASH_CYC
) (
  // Inputs of the controller
  input wire logic                 CLK_SYS_I,
  input wire logic                 RSTN_I,
  input wire logic                 PSEL_I,
  input wire logic                 PENABLE_I,
  input wire logic [WAKE_PINS-1:0] WAKE_PINS_N_I,
  input wire logic                 RTT_ALARM_N_I,
  input wire logic                 RTC_ALARM_N_I,
  // Outputs of the controller
  input wire logic                 PREADY_O,
  input wire logic                 CORE_CLK_EN_O,
  input wire logic                 MEM_CLK_EN_O,
  input wire logic [PERIPH_N-1:0]  PERIPH_CLK_EN_O,
  input wire logic [1:0]           CLK_SRC_SEL_O,
  input wire logic                 RC_RESTART_O,
  input wire logic [1:0]           FLASH_MODE_O,
  input wire logic                 SUPPLY_HOLD_O,
  input wire logic                 IO_HOLD_O,
  input wire logic                 FAST_STARTUP_O,
  input wire logic                 MASTER_CLOCK_READY_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  logic off;
  logic cause;
  assign off   = !MASTER_CLOCK_READY_O && !RC_RESTART_O;
  assign cause = !(&WAKE_PINS_N_I) || !RTT_ALARM_N_I || !RTC_ALARM_N_I;

  a_apb_one_wait: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  a_wait_clk_off: assert property (off |-> !CORE_CLK_EN_O && !MEM_CLK_EN_O &&
    PERIPH_CLK_EN_O == '0) else $error("clock runs in wait");
  a_supply_kept: assert property (SUPPLY_HOLD_O)
    else $error("supply dropped");
  a_flash_low: assert property (off |-> FLASH_MODE_O != 2'h3)
    else $error("flash left on in wait");
  a_flash_on: assert property (MASTER_CLOCK_READY_O |-> FLASH_MODE_O == 2'h3)
    else $error("flash not on while running");
  a_sleep_core_only: assert property (MASTER_CLOCK_READY_O && !CORE_CLK_EN_O |->
    MEM_CLK_EN_O) else $error("sleep stopped memories");
  a_io_frozen: assert property (!CORE_CLK_EN_O |-> IO_HOLD_O)
    else $error("io not held");
  a_wake_cause: assert property ($rose(FAST_STARTUP_O) |-> $past(off) &&
    $past(cause, 2))
    else $error("start-up without cause");
  a_restart_rc: assert property ($rose(FAST_STARTUP_O) |-> RC_RESTART_O &&
    CLK_SRC_SEL_O == 2'h0) else $error("restart not on rc");
  a_wake_bounded: assert property ($rose(RC_RESTART_O) |-> ##[1:1000] CORE_CLK_EN_O)
    else $error("wake too slow");
  a_resume_rc: assert property ($rose(CORE_CLK_EN_O) && $past(RC_RESTART_O) |->
    CLK_SRC_SEL_O == 2'h0) else $error("resumed off rc");

  c_fast_start: cover property ($rose(FAST_STARTUP_O));
  c_sleep: cover property (MASTER_CLOCK_READY_O && !CORE_CLK_EN_O);
  c_apb: cover property (PSEL_I && PREADY_O);
endmodule // lpc_ctrl_checker

bind lpc_ctrl lpc_ctrl_checker #(.PERIPH_N(PERIPH_N), .WAKE_FLASH_LIM(WAKE_FLASH_LIM)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .WAKE_PINS_N_I(WAKE_PINS_N_I), .RTT_ALARM_N_I(RTT_ALARM_N_I),
  .RTC_ALARM_N_I(RTC_ALARM_N_I), .PREADY_O(PREADY_O), .CORE_CLK_EN_O(CORE_CLK_EN_O),
  .MEM_CLK_EN_O(MEM_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
  .CLK_SRC_SEL_O(CLK_SRC_SEL_O), .RC_RESTART_O(RC_RESTART_O), .FLASH_MODE_O(FLASH_MODE_O),
  .SUPPLY_HOLD_O(SUPPLY_HOLD_O), .IO_HOLD_O(IO_HOLD_O), .FAST_STARTUP_O(FAST_STARTUP_O),
  .MASTER_CLOCK_READY_O(MASTER_CLOCK_READY_O));

// *** dv/lpc_ctrl_tb_top.sv ***
// Self-checking bench of the low-power mode controller.
// Assumes the package, design, oscillator model and checker are compiled first.
`timescale 1ns/100ps

module lpc_ctrl_tb_top;
  import lpc_pkg::*;
  logic        clk, rstn, psel, pen, pwr, wfe, wfi, deep, irq, dbg, rxe, inflash, err;
  logic        rtt_n, rtc_n, pready, pslverr, core_en, mem_en, rc_restart, rc_ready;
  logic        supply, io_hold, mcr, irq_o;
  logic [7:0]  paddr, periph;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] pins_n;
  logic [1:0]  src, fmode;
  logic [3:0]  div;
  int          bad_count, n_tests;

  lpc_ctrl #(.PERIPH_N(8), .WAKE_FLASH_LIM(20)) u_dut (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .WFE_I(wfe), .WFI_I(wfi), .DEEP_SLEEP_I(deep), .IRQ_I(irq),
    .DBG_EVENT_I(dbg), .RX_EVENT_I(rxe), .CODE_IN_FLASH_I(inflash),
    .WAKE_PINS_N_I(pins_n), .RTT_ALARM_N_I(rtt_n), .RTC_ALARM_N_I(rtc_n),
    .RC_READY_I(rc_ready), .CORE_CLK_EN_O(core_en), .MEM_CLK_EN_O(mem_en),
    .PERIPH_CLK_EN_O(periph), .CLK_SRC_SEL_O(src), .CLK_DIV_O(div),
    .RC_RESTART_O(rc_restart), .FLASH_MODE_O(fmode), .SUPPLY_HOLD_O(supply),
    .IO_HOLD_O(io_hold), .FAST_STARTUP_O(), .MASTER_CLOCK_READY_O(mcr), .IRQ_O(irq_o));

  lpc_rc_model #(.START_CYC(30)) u_rc (.clk_i(clk), .rstn_i(rstn), .restart_i(rc_restart),
    .mck_ready_i(mcr), .rc_ready_o(rc_ready));

  // ==========================================================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("BAD t=%0t no bus answer", $time);
      print_verdict();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rdat & m, exp);
  endtask

  task automatic wait_core(input logic v);
    int n;
    n = 0;
    while (core_en !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (core_en !== v) begin
      bad_count++;
      $display("BAD t=%0t core clock enable stuck", $time);
      print_verdict();
    end
  endtask

  // ==========================================================================
  // Clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("BAD t=%0t run limit reached", $time);
    print_verdict();
  end

  initial begin
    {psel, pen, pwr, wfe, wfi, deep, irq, dbg, rxe, inflash, rstn} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pins_n = 16'hffff;
    rtt_n = 1'b1;
    rtc_n = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_STATUS, 32'h1f, 32'h01);
    cmp({core_en, mem_en, supply, io_hold, fmode}, 32'h3b);
    rd(8'h1c, 32'hffffffff, 32'h0);
    cmp(err, 1'b1);
    wr(ADDR_PCER, 32'ha5);
    wr(ADDR_DIV, 32'h9);
    for (int s = 2; s >= 0; s--) begin
      wr(ADDR_MAIN_OSC, s << 1);
      repeat (2) @(posedge clk);
      cmp({periph, div, src}, {8'ha5, 4'h9, s[1:0]});
      rd(ADDR_MAIN_OSC, 32'h7, s << 1);
    end
    wr(ADDR_MAIN_OSC, 32'h6);
    rd(ADDR_MAIN_OSC, 32'h7, 32'h0);
    $display("end registers");
    for (int k = 0; k < 4; k++) begin
      inflash <= (k == 1);
      wr(ADDR_FSMR, 32'h30001 | (k << 21));
      wr(ADDR_MAIN_OSC, 32'h1);
      wait_core(1'b0);
      rd(ADDR_STATUS, 32'hf, 32'h6);
      cmp({mem_en, periph, fmode, io_hold}, {9'h0, ((k == 3) ? 2'h0 : k[1:0]), 1'b1});
      pins_n <= 16'hfffd;
      repeat (10) @(posedge clk);
      cmp(core_en, 1'b0);
      pins_n <= {15'h7fff, k[0] ^ k[1]};
      rtt_n <= (k != 1);
      rtc_n <= (k != 2);
      wait_core(1'b1);
      {pins_n, rtt_n, rtc_n} <= '1;
      cmp({src, fmode, io_hold}, 5'b00110);
      rd(ADDR_STATUS, 32'hf, 32'h1);
      rd(ADDR_IRQ_STAT, k == 1 ? 32'h8 : 32'hf, k == 1 ? 32'h8 : 32'h1);
      wr(ADDR_IRQ_STAT, 32'hf);
    end
    $display("end wait by request bit");
    wr(ADDR_FSMR, 32'h100001);
    for (int e = 0; e < 3; e++) begin
      wr(ADDR_IRQ_MASK, e == 2 ? 32'h0 : 32'h2);
      {irq, dbg, rxe} <= 3'b100 >> e;
      @(posedge clk);
      {irq, dbg, rxe} <= 3'b000;
      wfe <= 1'b1;
      @(posedge clk);
      wfe <= 1'b0;
      repeat (3) @(posedge clk);
      cmp({core_en, irq_o}, {1'b1, e != 2});
      rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
      wr(ADDR_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      cmp(irq_o, 1'b0);
    end
    $display("end refused wait");
    {deep, wfe, wfi} <= 3'b111;
    @(posedge clk);
    {deep, wfe, wfi} <= 3'b000;
    repeat (3) @(posedge clk);
    cmp(core_en, 1'b1);
    wfe <= 1'b1;
    @(posedge clk);
    wfe <= 1'b0;
    wait_core(1'b0);
    pins_n <= 16'hfffe;
    wait_core(1'b1);
    pins_n <= 16'hffff;
    $display("end wait by event");
    wr(ADDR_FSMR, 32'h1);
    wfi <= 1'b1;
    @(posedge clk);
    wfi <= 1'b0;
    wait_core(1'b0);
    cmp({mem_en, periph, mcr}, {1'b1, 8'ha5, 1'b1});
    irq <= 1'b1;
    wait_core(1'b1);
    irq <= 1'b0;
    rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
    $display("end sleep");
    print_verdict();
  end
endmodule // lpc_ctrl_tb_top
